// ==== dv/rtc_alarm_watchdog_irq_tb.sv ====
// Self-checking bench for the alarm, watchdog and test-output block
`timescale 1ns/100ps
`default_nettype none
module rtc_alarm_watchdog_irq_tb;
	import rtcaw_pkg::*;
	localparam int HALF = 8;
	localparam int PULSE = 20;
	localparam int T16 = 64 * HALF;
	logic        mclk, rst_n, tick_1hz, osc_run, on_battery, seen;
	logic        ce_n, oe_n, we_n, dq_oe, test_bit, irq_o, irq_oe, rst_o, rst_oe;
	logic [12:0] addr;
	logic [7:0]  host_d, dq_o, q;
	logic [3:0]  m, d;
	logic [31:0] tm, t, a;
	logic [3:0]  pats [7] = '{4'hf, 4'he, 4'hc, 4'h8, 4'h0, 4'h5, 4'ha};
	int          tk [4] = '{1, 4, 16, 64};
	int          failures, cmp_count, seed, n;
	wire logic [7:0] dq_bus = dq_oe ? dq_o : host_d;

	rtcaw_core #(.FT_HALF_CYCLES(HALF), .RST_PULSE_CYCLES(PULSE)) u_dut (
		.mclk(mclk), .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
		.dq_i(dq_bus), .dq_o(dq_o), .dq_oe(dq_oe), .tick_1hz(tick_1hz),
		.bcd_seconds(tm[7:0]), .bcd_minutes(tm[15:8]), .bcd_hours(tm[23:16]),
		.bcd_date(tm[31:24]), .osc_run(osc_run), .on_battery(on_battery),
		.freq_test_bit(test_bit), .irq_test_o(irq_o), .irq_test_oe(irq_oe),
		.rst_o(rst_o), .rst_oe(rst_oe));
	rtcaw_host u_host (.mclk(mclk), .dq_o(dq_bus), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .addr(addr), .dq_i(host_d));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic stop_test();
		$display("counts: %0d compares, %0d mismatches", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [12:0] ad, input logic [7:0] v);
		u_host.access(ad, 1'b1, v, q, seen);
	endtask
	task automatic rd(input logic [12:0] ad);
		u_host.access(ad, 1'b0, 8'h00, q, seen);
	endtask
	task automatic tick(input logic [31:0] tv);
		@(posedge mclk);
		tm <= tv;
		tick_1hz <= 1'b1;
		@(posedge mclk);
		tick_1hz <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	// Counts output changes over a span of edges
	task automatic edges(input int c);
		logic p;
		n = 0;
		p = irq_oe;
		repeat (c) begin
			@(posedge mclk);
			if (irq_oe !== p)
				n++;
			p = irq_oe;
		end
	endtask
	task automatic wait_wd(input logic on_rst, input int lim);
		n = 0;
		while ((on_rst ? rst_oe : irq_oe) !== 1'b1 && n < lim) begin
			@(posedge mclk);
			n++;
		end
	endtask
	function automatic logic [7:0] rbcd();
		rbcd = {4'h1 + 4'($unsigned($random(seed)) % 2), 4'($unsigned($random(seed)) % 10)};
	endfunction
	// Undefined mask patterns fall back to every second
	function automatic logic exp_af(input logic [3:0] mk, input logic [31:0] tv, input logic [31:0] av);
		logic [3:0] need;
		case (mk)
			4'he: need = 4'b0001;
			4'hc: need = 4'b0011;
			4'h8: need = 4'b0111;
			4'h0: need = 4'b1111;
			default: need = 4'b0000;
		endcase
		exp_af = 1'b1;
		for (int k = 0; k < 4; k++)
			if (need[k] && tv[8*k+:8] != av[8*k+:8])
				exp_af = 1'b0;
	endfunction

	initial begin
		#1_600_000;
		failures++;
		stop_test();
	end
	initial begin
		seed = 90;
		failures = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		tick_1hz = 1'b0;
		osc_run = 1'b1;
		on_battery = 1'b0;
		tm = 32'h00000000;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		rd(ADDR_WDOG);
		chk("wdog_reset", WDOG_RST, q);
		chk("read_oe", 1'b1, seen);
		rd(ADDR_ENABLES);
		chk("enables_reset", ENABLES_RST, q);
		chk("test_bit_reset", FT_RST, test_bit);
		chk("irq_data", 1'b0, irq_o);
		rd(13'h0100);
		chk("unmapped_oe", 1'b0, seen);
		wr(ADDR_FLAGS, 8'hff);
		rd(ADDR_FLAGS);
		chk("flags_readonly", 8'h00, q);
		$display("test reset done");
		for (int i = 0; i < 21; i++) begin
			m = pats[i % 7];
			t = {rbcd(), rbcd(), rbcd(), rbcd()};
			d = 4'($random(seed));
			a = t ^ {7'h00, d[3], 7'h00, d[2], 7'h00, d[1], 7'h00, d[0]};
			for (int k = 0; k < 4; k++)
				wr(ADDR_ALM_SEC + 13'(k), {m[k], a[8*k+:7]});
			rd(ADDR_ALM_SEC);
			chk("alarm_seconds", {m[0], a[6:0]}, q);
			rd(ADDR_FLAGS);
			tick(t);
			rd(ADDR_FLAGS);
			chk("alarm_match", exp_af(m, t, a), q[FLAG_AF_BIT]);
		end
		$display("test alarm match done");
		for (int k = 0; k < 4; k++)
			wr(ADDR_ALM_SEC + 13'(k), 8'h80);
		rd(ADDR_FLAGS);
		tick(tm);
		chk("irq_disabled", 1'b0, irq_oe);
		wr(ADDR_ENABLES, 8'h80);
		rd(ADDR_ENABLES);
		chk("enables_rb", 8'h80, q);
		rd(ADDR_FLAGS);
		tick(tm);
		chk("irq_enabled", 1'b1, irq_oe);
		rd(ADDR_FLAGS);
		chk("irq_release", 1'b0, irq_oe);
		chk("flag_held", 1'b1, q[FLAG_AF_BIT]);
		rd(ADDR_FLAGS);
		chk("flag_cleared", 1'b0, q[FLAG_AF_BIT]);
		on_battery <= 1'b1;
		tick(tm);
		chk("battery_one_enable", 1'b0, irq_oe);
		on_battery <= 1'b0;
		wr(ADDR_ENABLES, 8'ha0);
		rd(ADDR_FLAGS);
		on_battery <= 1'b1;
		tick(tm);
		chk("battery_both", 1'b1, irq_oe);
		on_battery <= 1'b0;
		tick(tm);
		rd(ADDR_ENABLES);
		chk("powerup_enables", 8'h00, q);
		rd(ADDR_FLAGS);
		chk("powerup_flag", 1'b1, q[FLAG_AF_BIT]);
		rd(ADDR_FLAGS);
		$display("test alarm irq done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_WDOG, {6'h01, 2'(i)});
			rd(ADDR_WDOG);
			chk("wdog_rb", {6'h01, 2'(i)}, q);
			wait_wd(1'b0, 40000);
			chk("wdog_early", 1'b1, n >= tk[i] * T16 - 60);
			chk("wdog_late", 1'b1, n <= tk[i] * T16 + 40);
			chk("wdog_no_pulse", 1'b0, rst_oe);
			repeat (50) @(posedge mclk);
			chk("wdog_irq_held", 1'b1, irq_oe);
			rd(ADDR_FLAGS);
			chk("wdog_flag", 1'b1, q[FLAG_WF_BIT]);
			chk("wdog_irq_release", 1'b0, irq_oe);
		end
		wr(ADDR_WDOG, 8'h05);
		for (int i = 0; i < 4; i++) begin
			repeat (1400) @(posedge mclk);
			chk("wdog_kicked", 1'b0, irq_oe);
			rd(ADDR_WDOG);
		end
		wr(ADDR_WDOG, 8'h00);
		wait_wd(1'b0, 3000);
		chk("wdog_off", 3000, n);
		$display("test watchdog irq done");
		wr(ADDR_DAY, 8'h40);
		chk("test_bit_set", 1'b1, test_bit);
		rd(ADDR_DAY);
		chk("test_bit_rb", 8'h40, q);
		wr(ADDR_WDOG, 8'h84);
		wait_wd(1'b1, 1000);
		n = 0;
		while (rst_oe === 1'b1 && n < 1000) begin
			@(posedge mclk);
			n++;
		end
		chk("pulse_width", PULSE, n);
		chk("rst_data", 1'b0, rst_o);
		chk("pulse_test_bit", 1'b0, test_bit);
		rd(ADDR_FLAGS);
		chk("pulse_flag", 1'b1, q[FLAG_WF_BIT]);
		rd(ADDR_WDOG);
		chk("pulse_wdog_clr", 8'h00, q);
		$display("test watchdog reset done");
		wr(ADDR_DAY, 8'h40);
		edges(160);
		chk("wave_edges", 20, n);
		wr(ADDR_ENABLES, 8'h80);
		repeat (3) @(posedge mclk);
		edges(80);
		chk("wave_alarm_en", 0, n);
		wr(ADDR_ENABLES, 8'h00);
		osc_run <= 1'b0;
		repeat (3) @(posedge mclk);
		edges(80);
		chk("wave_osc_off", 0, n);
		osc_run <= 1'b1;
		wr(ADDR_WDOG, 8'h04);
		wait_wd(1'b0, 1000);
		edges(80);
		chk("wdog_wins_edges", 0, n);
		chk("wdog_wins_level", 1'b1, irq_oe);
		rd(ADDR_FLAGS);
		$display("test wave done");
		rst_n <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk("test_bit_power", 1'b0, test_bit);
		rd(ADDR_WDOG);
		chk("wdog_power", 8'h00, q);
		$display("test second reset done");
		stop_test();
	end
endmodule
`default_nettype wire

// ==== dv/rtcaw_host.sv ====
// Host processor model on the bytewide bus
`timescale 1ns/100ps
`default_nettype none
module rtcaw_host (
	input  wire logic        mclk,
	input  wire logic [7:0]  dq_o,
	input  wire logic        dq_oe,
	output logic             ce_n,
	output logic             oe_n,
	output logic             we_n,
	output logic      [12:0] addr,
	output logic      [7:0]  dq_i
);
	logic [7:0] last_q = 8'h00;
	initial begin
		ce_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
		addr = 13'h0000;
		dq_i = 8'hff;
	end
	// Whole cycle of 17 edges, a length that guarantees a clear
	task automatic access(input logic [12:0] a, input logic wr, input logic [7:0] d,
		output logic [7:0] q, output logic seen);
		@(posedge mclk);
		addr <= a;
		ce_n <= 1'b0;
		oe_n <= wr;
		we_n <= ~wr;
		dq_i <= wr ? d : ~last_q;
		repeat (10) @(posedge mclk);
		seen = dq_oe;
		q = dq_o;
		last_q = wr ? d : q;
		ce_n <= 1'b1;
		oe_n <= 1'b1;
		we_n <= 1'b1;
		// Released lines never keep the last value
		dq_i <= ~last_q;
		repeat (6) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

// ==== pkg/rtcaw_pkg.sv ====
// Constants shared by the alarm, watchdog and frequency-test block
`default_nettype none
package rtcaw_pkg;
	// Register addresses on the bytewide bus
	localparam logic [12:0] ADDR_FLAGS     = 13'h1ff0;
	localparam logic [12:0] ADDR_ALM_SEC   = 13'h1ff2;
	localparam logic [12:0] ADDR_ALM_MIN   = 13'h1ff3;
	localparam logic [12:0] ADDR_ALM_HOUR  = 13'h1ff4;
	localparam logic [12:0] ADDR_ALM_DATE  = 13'h1ff5;
	localparam logic [12:0] ADDR_ENABLES   = 13'h1ff6;
	localparam logic [12:0] ADDR_WDOG      = 13'h1ff7;
	localparam logic [12:0] ADDR_DAY       = 13'h1ffc;

	// Field positions
	localparam int FLAG_WF_BIT   = 7;
	localparam int FLAG_AF_BIT   = 6;
	localparam int ENA_AE_BIT    = 7;
	localparam int ENA_ABE_BIT   = 5;
	localparam int ALM_MASK_BIT  = 7;
	localparam int WD_STEER_BIT  = 7;
	localparam int WD_MULT_HI    = 6;
	localparam int WD_MULT_LO    = 2;
	localparam int DAY_FT_BIT    = 6;

	// Reset values
	localparam logic [7:0] ALARM_RST   = 8'h00;
	localparam logic [7:0] ENABLES_RST = 8'h00;
	localparam logic [7:0] WDOG_RST    = 8'h00;
	localparam logic       FT_RST      = 1'b0;

	// Timing
	localparam int CLK_HZ         = 50_000_000;
	localparam int FT_HZ          = 512;
	localparam int FT_HALF_CYC    = CLK_HZ / (2 * FT_HZ);
	localparam int HALF_PER_16TH  = (2 * FT_HZ) / 16;
	localparam int RST_PULSE_MS   = 100;
	localparam int RST_PULSE_CYC  = (CLK_HZ / 1000) * RST_PULSE_MS;

	// Sixteenths of a second per resolution code
	localparam logic [6:0] RES_TICKS_0 = 7'h01;
	localparam logic [6:0] RES_TICKS_1 = 7'h04;
	localparam logic [6:0] RES_TICKS_2 = 7'h10;
	localparam logic [6:0] RES_TICKS_3 = 7'h40;

	// Synchroniser idle value: strobes high, address and data low
	localparam logic [23:0] PIN_IDLE = 24'he00000;

	typedef enum logic [2:0] {
		WD_IDLE  = 3'b001,
		WD_COUNT = 3'b010,
		WD_PULSE = 3'b100
	} rtcaw_wd_t;
endpackage
`default_nettype wire

// ==== rtl/rtcaw_core.sv ====
// Alarm, watchdog and frequency-test logic behind the bytewide bus
`timescale 1ns/100ps
`default_nettype none
module rtcaw_core
	import rtcaw_pkg::*;
#(
	parameter int FT_HALF_CYCLES  = rtcaw_pkg::FT_HALF_CYC,
	parameter int RST_PULSE_CYCLES = rtcaw_pkg::RST_PULSE_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [12:0] addr,
	input  wire logic [7:0]  dq_i,
	output logic      [7:0]  dq_o,
	output logic             dq_oe,
	input  wire logic        tick_1hz,
	input  wire logic [7:0]  bcd_seconds,
	input  wire logic [7:0]  bcd_minutes,
	input  wire logic [7:0]  bcd_hours,
	input  wire logic [7:0]  bcd_date,
	input  wire logic        osc_run,
	input  wire logic        on_battery,
	output logic             freq_test_bit,
	output logic             irq_test_o,
	output logic             irq_test_oe,
	output logic             rst_o,
	output logic             rst_oe
);
	import rtcaw_pkg::*;

	localparam int SW = $clog2(FT_HALF_CYCLES + 1);
	localparam int PW = $clog2(RST_PULSE_CYCLES + 1);

	function automatic logic [10:0] wd_target(input logic [7:0] r);
		logic [6:0] res;
		unique case (r[1:0])
			2'b00: res = RES_TICKS_0;
			2'b01: res = RES_TICKS_1;
			2'b10: res = RES_TICKS_2;
			2'b11: res = RES_TICKS_3;
		endcase
		wd_target = 11'(r[WD_MULT_HI:WD_MULT_LO]) * 11'(res);
	endfunction

	function automatic logic is_ours(input logic [12:0] a);
		is_ours = (a == ADDR_FLAGS) || (a == ADDR_ALM_SEC) || (a == ADDR_ALM_MIN) ||
			(a == ADDR_ALM_HOUR) || (a == ADDR_ALM_DATE) || (a == ADDR_ENABLES) ||
			(a == ADDR_WDOG) || (a == ADDR_DAY);
	endfunction

	// Pin synchroniser, three stages with agreement filter
	logic [23:0] pin_raw;
	logic [23:0] s1_q;
	logic [23:0] s2_q;
	logic [23:0] s3_q;
	logic [23:0] pin_q;
	logic [23:0] agree;

	assign pin_raw = {ce_n, oe_n, we_n, addr, dq_i};
	assign agree   = ~(s2_q ^ s3_q);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s1_q  <= PIN_IDLE;
			s2_q  <= PIN_IDLE;
			s3_q  <= PIN_IDLE;
			pin_q <= PIN_IDLE;
		end else begin
			s1_q  <= pin_raw;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			pin_q <= (pin_q & ~agree) | (s3_q & agree);
		end
	end

	logic        ce_n_f;
	logic        oe_n_f;
	logic        we_n_f;
	logic [12:0] addr_f;
	logic [7:0]  dq_f;
	assign ce_n_f = pin_q[23];
	assign oe_n_f = pin_q[22];
	assign we_n_f = pin_q[21];
	assign addr_f = pin_q[20:8];
	assign dq_f   = pin_q[7:0];

	// Bus cycle tracking; host is locked out while on battery
	logic        acc_live;
	logic        acc_q;
	logic        acc_wr_q;
	logic [12:0] acc_addr_q;
	logic [7:0]  wr_data_q;
	logic        acc_start;
	logic        acc_end;
	logic        wr_commit;

	assign acc_live  = ~ce_n_f & (~oe_n_f | ~we_n_f) & ~on_battery;
	assign acc_start = acc_live & ~acc_q;
	assign acc_end   = ~acc_live & acc_q;
	assign wr_commit = acc_end & acc_wr_q;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			acc_q      <= 1'b0;
			acc_wr_q   <= 1'b0;
			acc_addr_q <= 13'h0000;
			wr_data_q  <= 8'h00;
		end else begin
			acc_q <= acc_live;
			if (acc_start)
				acc_addr_q <= addr_f;
			if (acc_start)
				acc_wr_q <= ~we_n_f;
			else if (acc_live & ~we_n_f)
				acc_wr_q <= 1'b1;
			if (acc_live & ~we_n_f)
				wr_data_q <= dq_f;
		end
	end

	// Register state
	logic [7:0] alm_sec_q;
	logic [7:0] alm_min_q;
	logic [7:0] alm_hour_q;
	logic [7:0] alm_date_q;
	logic [7:0] enables_q;
	logic [7:0] wdog_q;
	logic       ft_q;
	logic       af_q;
	logic       wf_q;
	logic       alarm_irq_q;
	logic       wdog_irq_q;
	logic       batt_q;

	logic flags_start;
	logic flags_end;
	logic flags_rd_end;
	logic wdog_touch;
	logic wr_alm_sec;
	logic wr_alm_min;
	logic wr_alm_hour;
	logic wr_alm_date;
	logic wr_enables;
	logic wr_wdog;
	logic wr_day;
	logic power_up;

	assign flags_start  = acc_start & (addr_f == ADDR_FLAGS);
	assign flags_end    = acc_end & (acc_addr_q == ADDR_FLAGS);
	assign flags_rd_end = flags_end & ~acc_wr_q;
	assign wdog_touch   = (acc_start & (addr_f == ADDR_WDOG)) | wr_wdog;
	assign wr_alm_sec   = wr_commit & (acc_addr_q == ADDR_ALM_SEC);
	assign wr_alm_min   = wr_commit & (acc_addr_q == ADDR_ALM_MIN);
	assign wr_alm_hour  = wr_commit & (acc_addr_q == ADDR_ALM_HOUR);
	assign wr_alm_date  = wr_commit & (acc_addr_q == ADDR_ALM_DATE);
	assign wr_enables   = wr_commit & (acc_addr_q == ADDR_ENABLES);
	assign wr_wdog      = wr_commit & (acc_addr_q == ADDR_WDOG);
	assign wr_day       = wr_commit & (acc_addr_q == ADDR_DAY);
	assign power_up     = batt_q & ~on_battery;

	// Alarm comparison
	logic [3:0] alm_mask;
	logic       sec_eq;
	logic       min_eq;
	logic       hour_eq;
	logic       date_eq;
	logic       match_cond;
	logic       alarm_match;
	logic       alarm_irq_set;
	logic       ae;
	logic       abe;

	assign alm_mask = {alm_date_q[ALM_MASK_BIT], alm_hour_q[ALM_MASK_BIT],
		alm_min_q[ALM_MASK_BIT], alm_sec_q[ALM_MASK_BIT]};
	assign sec_eq   = bcd_seconds[6:0] == alm_sec_q[6:0];
	assign min_eq   = bcd_minutes[6:0] == alm_min_q[6:0];
	assign hour_eq  = bcd_hours[5:0] == alm_hour_q[5:0];
	assign date_eq  = bcd_date[5:0] == alm_date_q[5:0];
	// Unlisted patterns fall through to every second so a bad setup shows
	assign match_cond = (alm_mask == 4'he) ? sec_eq :
		(alm_mask == 4'hc) ? (sec_eq & min_eq) :
		(alm_mask == 4'h8) ? (sec_eq & min_eq & hour_eq) :
		(alm_mask == 4'h0) ? (sec_eq & min_eq & hour_eq & date_eq) : 1'b1;
	assign alarm_match   = tick_1hz & match_cond;
	assign ae            = enables_q[ENA_AE_BIT];
	assign abe           = enables_q[ENA_ABE_BIT];
	assign alarm_irq_set = alarm_match & ae & (~on_battery | abe);

	// Prescaler: 512 Hz square wave and 1/16 s ticks
	logic [SW-1:0] sub_cnt_q;
	logic          sq512_q;
	logic [5:0]    t16_cnt_q;
	logic          half_tick;
	logic          t16;

	assign half_tick = osc_run & (sub_cnt_q == SW'(FT_HALF_CYCLES - 1));
	assign t16       = half_tick & (t16_cnt_q == 6'(HALF_PER_16TH - 1));

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sub_cnt_q <= '0;
			sq512_q   <= 1'b1;
			t16_cnt_q <= 6'h00;
		end else begin
			if (half_tick)
				sub_cnt_q <= '0;
			else if (osc_run)
				sub_cnt_q <= sub_cnt_q + SW'(1);
			if (half_tick)
				sq512_q <= ~sq512_q;
			// Restart re-phases the tick, costing at most 1/16 s
			if (wdog_touch)
				t16_cnt_q <= 6'h00;
			else if (t16)
				t16_cnt_q <= 6'h00;
			else if (half_tick)
				t16_cnt_q <= t16_cnt_q + 6'h01;
		end
	end

	// Watchdog
	rtcaw_wd_t     wd_state_q;
	rtcaw_wd_t     wd_state_d;
	logic [10:0]   wd_cnt_q;
	logic [PW-1:0] pulse_cnt_q;
	logic          wd_en;
	logic          steer;
	logic          expire;
	logic          steer_expire;
	logic          pulse_done;

	assign steer        = wdog_q[WD_STEER_BIT];
	assign wd_en        = wdog_q[WD_MULT_HI:WD_MULT_LO] != 5'h00;
	assign expire       = (wd_state_q == WD_COUNT) & t16 & wd_en &
		((wd_cnt_q + 11'h001) == wd_target(wdog_q));
	assign steer_expire = expire & steer;
	assign pulse_done   = pulse_cnt_q == PW'(RST_PULSE_CYCLES - 1);

	always_comb begin
		wd_state_d = wd_state_q;
		unique case (wd_state_q)
			WD_IDLE: begin
				if (wd_en)
					wd_state_d = WD_COUNT;
			end
			WD_COUNT: begin
				if (steer_expire)
					wd_state_d = WD_PULSE;
				else if (!wd_en)
					wd_state_d = WD_IDLE;
			end
			WD_PULSE: begin
				if (pulse_done)
					wd_state_d = WD_IDLE;
			end
			default: wd_state_d = WD_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wd_state_q  <= WD_IDLE;
			wd_cnt_q    <= 11'h000;
			pulse_cnt_q <= '0;
		end else begin
			wd_state_q <= wd_state_d;
			if (wdog_touch || expire || wd_state_q != WD_COUNT)
				wd_cnt_q <= 11'h000;
			else if (t16)
				wd_cnt_q <= wd_cnt_q + 11'h001;
			if (wd_state_q == WD_PULSE)
				pulse_cnt_q <= pulse_cnt_q + PW'(1);
			else
				pulse_cnt_q <= '0;
		end
	end

	// Registers: hardware set wins over host clear
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			alm_sec_q   <= ALARM_RST;
			alm_min_q   <= ALARM_RST;
			alm_hour_q  <= ALARM_RST;
			alm_date_q  <= ALARM_RST;
			enables_q   <= ENABLES_RST;
			wdog_q      <= WDOG_RST;
			ft_q        <= FT_RST;
			af_q        <= 1'b0;
			wf_q        <= 1'b0;
			alarm_irq_q <= 1'b0;
			wdog_irq_q  <= 1'b0;
			batt_q      <= 1'b0;
		end else begin
			batt_q <= on_battery;
			if (wr_alm_sec)
				alm_sec_q <= wr_data_q;
			if (wr_alm_min)
				alm_min_q <= wr_data_q;
			if (wr_alm_hour)
				alm_hour_q <= wr_data_q;
			if (wr_alm_date)
				alm_date_q <= wr_data_q;
			if (power_up) begin
				enables_q[ENA_AE_BIT]  <= 1'b0;
				enables_q[ENA_ABE_BIT] <= 1'b0;
			end else if (wr_enables)
				enables_q <= wr_data_q;
			if (steer_expire)
				wdog_q <= WDOG_RST;
			else if (wr_wdog)
				wdog_q <= wr_data_q;
			if (steer_expire)
				ft_q <= 1'b0;
			else if (wr_day)
				ft_q <= wr_data_q[DAY_FT_BIT];
			if (alarm_match)
				af_q <= 1'b1;
			else if (flags_end)
				af_q <= 1'b0;
			if (alarm_irq_set)
				alarm_irq_q <= 1'b1;
			else if (flags_start)
				alarm_irq_q <= 1'b0;
			if (expire)
				wf_q <= 1'b1;
			else if (flags_rd_end || wdog_touch)
				wf_q <= 1'b0;
			if (expire && !steer)
				wdog_irq_q <= 1'b1;
			else if (flags_rd_end || wdog_touch)
				wdog_irq_q <= 1'b0;
		end
	end

	// Read path; battery low and zero bits read as zero
	logic [7:0] flags_val;
	logic [7:0] rd_mux;
	logic [7:0] dq_q;

	assign flags_val = {wf_q, af_q, 6'h00};
	assign rd_mux = (addr_f == ADDR_FLAGS) ? flags_val :
		(addr_f == ADDR_ALM_SEC) ? alm_sec_q :
		(addr_f == ADDR_ALM_MIN) ? alm_min_q :
		(addr_f == ADDR_ALM_HOUR) ? alm_hour_q :
		(addr_f == ADDR_ALM_DATE) ? alm_date_q :
		(addr_f == ADDR_ENABLES) ? enables_q :
		(addr_f == ADDR_WDOG) ? wdog_q :
		(addr_f == ADDR_DAY) ? {1'b0, ft_q, 6'h00} : 8'h00;

	always_ff @(posedge mclk) begin
		if (!rst_n)
			dq_q <= 8'h00;
		else
			dq_q <= rd_mux;
	end

	assign dq_o  = dq_q;
	assign dq_oe = acc_live & acc_q & ~oe_n_f & we_n_f & is_ours(addr_f);

	// Interrupt/test pin: watchdog and alarm win over the test toggle
	logic irq_assert;
	logic ft_on;

	assign freq_test_bit = ft_q;
	assign irq_assert    = alarm_irq_q | wdog_irq_q;
	assign ft_on         = ft_q & ~ae & (steer | (wdog_q == 8'h00)) & osc_run;
	assign irq_test_o    = 1'b0;
	assign irq_test_oe   = irq_assert | (ft_on & ~sq512_q);
	assign rst_o         = 1'b0;
	assign rst_oe        = wd_state_q == WD_PULSE;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence flags_done_s;
		flags_end ##0 !alarm_match;
	endsequence

	sequence steered_expiry_s;
		steer_expire ##1 (wd_state_q == WD_PULSE);
	endsequence

	af_set_match_a: assert property (alarm_match |=> af_q)
		else $error("alarm flag not set on match");
	af_clear_end_a: assert property (flags_done_s |=> !af_q && !alarm_irq_q)
		else $error("alarm flag not cleared after flags access");
	irq_release_a: assert property (flags_start && !alarm_irq_set |=> !alarm_irq_q)
		else $error("alarm interrupt not released on flags access");
	mask_default_a: assert property (tick_1hz && !(alm_mask inside {4'hf, 4'he, 4'hc, 4'h8, 4'h0})
		|-> alarm_match)
		else $error("bad mask pattern did not alarm every second");
	alarm_gate_a: assert property (alarm_match && !ae && !alarm_irq_q && !wdog_irq_q |=> !irq_assert)
		else $error("alarm drove interrupt while disabled");
	batt_alarm_a: assert property (alarm_match && on_battery && ae && abe |=> irq_test_oe)
		else $error("battery alarm did not pull interrupt low");
	powerup_clear_a: assert property (power_up |=> !ae && !abe)
		else $error("enables survive power-up");
	ft_toggle_a: assert property (half_tick |=> sq512_q != $past(sq512_q))
		else $error("test square wave missed a toggle");
	wd_clear_a: assert property (steered_expiry_s |-> wdog_q == 8'h00 && !ft_q)
		else $error("steered expiry left watchdog or test bit set");
	wd_pulse_len_a: assert property ($rose(rst_oe) |-> rst_oe [*8] ##0 (pulse_cnt_q < PW'(RST_PULSE_CYCLES)))
		else $error("reset pulse malformed");
	wd_irq_route_a: assert property (expire && !steer |=> irq_test_oe && wf_q)
		else $error("unsteered expiry did not interrupt");
	wd_restart_a: assert property (wdog_touch |=> wd_cnt_q == 11'h000)
		else $error("watchdog access did not restart timeout");
	wd_off_a: assert property (wdog_q == 8'h00 |=> wd_state_q != WD_COUNT)
		else $error("watchdog counting while register zero");
	wd_ft_denied_a: assert property (wdog_irq_q && !steer |-> irq_test_oe)
		else $error("test toggle overrode watchdog interrupt");
endmodule
`default_nettype wire
